// *** common/ffc_pkg.sv ***
// Purpose: Shared constants and carriers for the flat field correction core
// Assumes: One pixel clock, synchronous active-low reset
// Notes: Coefficient word is 16 bits, two bytes little-endian
package ffc_pkg;
  localparam int COMP_W = 16;
  localparam int COEF_W = 16;
  localparam int ADDR_W = 32;
  localparam int GAIN_LSB = 0;
  localparam int GAIN_W = 10;
  localparam int GAIN_FRAC = 8;
  localparam int OFS_LSB = 10;
  localparam int OFS_W = 6;
  localparam int BYTE_W = 8;
  localparam int DEPTH_W = 3;
  // Depth codes
  localparam logic [2:0] DEPTH_8 = 3'h0;
  localparam logic [2:0] DEPTH_10 = 3'h1;
  localparam logic [2:0] DEPTH_12 = 3'h2;
  localparam logic [2:0] DEPTH_14 = 3'h3;
  localparam logic [2:0] DEPTH_16 = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h0;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 32'h1;

  typedef struct packed {
    logic [COMP_W-1:0] data;
    logic sof;
  } ffc_comp_t;

  typedef struct packed {
    logic [COMP_W-1:0] data;
    logic sof;
    logic [COEF_W-1:0] coef;
    logic use_coef;
  } ffc_job_t;
endpackage : ffc_pkg

// *** logic/ffc_core.sv ***
// Purpose: Per-component flat field correction on the raw camera stream
// Assumes: Coefficient memory answers a request with one word, any latency
// Notes: A two-entry skid buffer sits on the output path; only one
//   component is in flight, so throughput follows the fetch round trip
`timescale 1ns/1ps
module ffc_core
  import ffc_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic sys_clk, // Pixel clock
  input wire logic rst_n, // Sync reset, active low
  input wire logic correction_enable_control, // Correction on
  input wire logic [DEPTH_W-1:0] depth_sel, // Component bit depth code
  input wire logic in_valid, // Raw component valid
  output logic in_ready, // Core can take a raw component
  input wire logic [COMP_W-1:0] in_data, // Raw component, low aligned
  input wire logic in_sof, // First component of a frame
  output logic coef_req, // Coefficient fetch request
  output logic [ADDR_W-1:0] coef_addr, // Coefficient word index
  input wire logic coef_ack, // Fetch accepted
  input wire logic coef_rvalid, // Coefficient word returned
  input wire logic [COEF_W-1:0] coef_rdata, // Bytes as stored, low first
  output logic out_valid, // Corrected component valid
  input wire logic out_ready, // Later stage can accept
  output logic [COMP_W-1:0] out_data, // Corrected component
  output logic out_sof // First component of a frame
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_REQ = 3'b010,
    ST_WAIT = 3'b100
  } ffc_state_t;

  ffc_state_t state;
  ffc_job_t job;
  logic job_full;
  logic [ADDR_W-1:0] pos;
  ffc_comp_t buf_q [BUF_DEPTH];
  // Pointer and count widths follow the buffer depth
  localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CNT_W = $clog2(BUF_DEPTH + 1);
  logic [CNT_W-1:0] buf_cnt;
  logic [PTR_W-1:0] buf_wr_ptr;
  logic [PTR_W-1:0] buf_rd_ptr;
  logic calc_fire;
  logic [COMP_W-1:0] calc_val;
  logic buf_in_ready;
  logic take;
  logic take_fetch;
  logic out_fire;

  // Ceiling of the active depth; unknown codes take the widest
  function automatic logic [COMP_W-1:0] max_code(input logic [2:0] d);
    unique case (d)
      DEPTH_8: max_code = 16'h00ff;
      DEPTH_10: max_code = 16'h03ff;
      DEPTH_12: max_code = 16'h0fff;
      DEPTH_14: max_code = 16'h3fff;
      default: max_code = 16'hffff;
    endcase
  endfunction : max_code

  // Ring step shared by both buffer pointers
  function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
    if (p == PTR_W'(BUF_DEPTH - 1)) begin
      ptr_next = '0;
    end else begin
      ptr_next = p + PTR_W'(1);
    end
  endfunction : ptr_next

  function automatic logic [COMP_W-1:0] correct(
    input logic [COMP_W-1:0] raw,
    input logic [COEF_W-1:0] coef,
    input logic [2:0] d
  );
    logic [OFS_W-1:0] ofs;
    logic [GAIN_W-1:0] gain;
    logic [COMP_W-1:0] diff;
    logic [COMP_W+GAIN_W-1:0] prod;
    logic [COMP_W+GAIN_W-GAIN_FRAC-1:0] whole;
    ofs = coef[OFS_LSB +: OFS_W];
    gain = coef[GAIN_LSB +: GAIN_W];
    diff = '0;
    if (raw > COMP_W'(ofs)) begin
      diff = raw - COMP_W'(ofs);
    end
    prod = (COMP_W+GAIN_W)'(diff) * (COMP_W+GAIN_W)'(gain);
    whole = prod[COMP_W+GAIN_W-1:GAIN_FRAC];
    if (whole > (COMP_W+GAIN_W-GAIN_FRAC)'(max_code(d))) begin
      correct = max_code(d);
    end else begin
      correct = whole[COMP_W-1:0];
    end
  endfunction : correct

  logic [COEF_W-1:0] coef_word;
  assign coef_word = {coef_rdata[BYTE_W +: BYTE_W], coef_rdata[0 +: BYTE_W]};

  // Job slot is free again once its result enters the buffer
  assign in_ready = !job_full;
  // Handshake events shared by several processes
  assign take = in_valid && in_ready;
  assign take_fetch = take && correction_enable_control;
  assign out_fire = out_valid && out_ready;
  // Depth is read here, at compute time, not latched with the component:
  // the stage feeding this block keeps it steady while one is in flight
  assign calc_fire = job_full && (state == ST_IDLE) && buf_in_ready;
  assign calc_val = job.use_coef ? correct(job.data, job.coef, depth_sel)
                                 : job.data;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      job <= '0;
      job_full <= 1'b0;
    end else if (take) begin
      job.data <= in_data;
      job.sof <= in_sof;
      job.coef <= '0;
      job.use_coef <= correction_enable_control;
      job_full <= 1'b1;
    end else begin
      if (state == ST_WAIT && coef_rvalid) begin
        job.coef <= coef_word;
      end
      if (calc_fire) begin
        job_full <= 1'b0;
      end
    end
  end

  // one word per corrected component; bypassed components do not advance the index
  // A frame start restarts the index even when that component is bypassed,
  // so the first corrected component of a frame never reuses an old index
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pos <= ADDR_ZERO;
    end else if (take && in_sof) begin
      pos <= correction_enable_control ? ADDR_ONE : ADDR_ZERO;
    end else if (take_fetch) begin
      pos <= pos + ADDR_ONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      coef_addr <= ADDR_ZERO;
    end else if (take_fetch) begin
      coef_addr <= in_sof ? ADDR_ZERO : pos;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (take_fetch) begin
            state <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (coef_ack) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (coef_rvalid) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Request stands until accepted; the address is held with it
  assign coef_req = (state == ST_REQ);

  // Two entries so a receiver stall in one cycle loses nothing
  assign buf_in_ready = (buf_cnt != CNT_W'(BUF_DEPTH));
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      buf_cnt <= '0;
      buf_wr_ptr <= '0;
      buf_rd_ptr <= '0;
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_q[i] <= '0;
      end
    end else begin
      if (calc_fire) begin
        buf_q[buf_wr_ptr].data <= calc_val;
        buf_q[buf_wr_ptr].sof <= job.sof;
        buf_wr_ptr <= ptr_next(buf_wr_ptr);
      end
      if (out_fire) begin
        buf_rd_ptr <= ptr_next(buf_rd_ptr);
      end
      // A write and a read in one cycle leave the count unchanged
      if (calc_fire && !out_fire) begin
        buf_cnt <= buf_cnt + CNT_W'(1);
      end else if (!calc_fire && out_fire) begin
        buf_cnt <= buf_cnt - CNT_W'(1);
      end
    end
  end

  assign out_valid = (buf_cnt != '0);
  assign out_data = buf_q[buf_rd_ptr].data;
  assign out_sof = buf_q[buf_rd_ptr].sof;
endmodule : ffc_core

// *** verif/ffc_core_props.sv ***
// Purpose: Port assertions for ffc_core
// Assumes: One clock, sync reset
// Notes: Bound after the module
`timescale 1ns/1ps
module ffc_core_props
  import ffc_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic correction_enable_control, // Enable
  input wire logic in_valid, // In valid
  input wire logic in_ready, // In ready
  input wire logic [COMP_W-1:0] in_data, // Raw
  input wire logic in_sof, // Frame start
  input wire logic coef_req, // Fetch
  input wire logic [ADDR_W-1:0] coef_addr, // Index
  input wire logic coef_ack, // Accept
  input wire logic out_valid, // Out valid
  input wire logic out_ready, // Out ready
  input wire logic [COMP_W-1:0] out_data // Result
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_take;
    in_valid && in_ready;
  endsequence
  // Bypass into an empty buffer has a fixed latency
  sequence s_byp;
    s_take ##0 (!correction_enable_control && !out_valid);
  endsequence
  chk_req_hold: assert property (
    coef_req && !coef_ack |=> coef_req && $stable(coef_addr))
    else $error("fetch dropped early");
  chk_en_req: assert property (
    s_take ##0 correction_enable_control |=> coef_req)
    else $error("no fetch");
  chk_off_nofetch: assert property (
    s_take ##0 !correction_enable_control |=> !coef_req[*2])
    else $error("fetch while off");
  chk_sof_addr: assert property (
    s_take ##0 (correction_enable_control && in_sof)
    |=> coef_addr == ADDR_ZERO)
    else $error("frame index");
  chk_req_busy: assert property (
    coef_req |-> !in_ready)
    else $error("taken during fetch");
  chk_out_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output lost");
  chk_byp_lat: assert property (
    s_byp |-> ##2 out_valid)
    else $error("bypass latency");
  chk_byp_data: assert property (
    s_byp |-> ##2 out_data == $past(in_data, 2))
    else $error("bypass data");
endmodule : ffc_core_props
bind ffc_core ffc_core_props u_props (.sys_clk, .rst_n,
  .correction_enable_control, .in_valid, .in_ready, .in_data, .in_sof,
  .coef_req, .coef_addr, .coef_ack, .out_valid, .out_ready, .out_data);

// *** verif/ffc_mem_model.sv ***
// Purpose: Coefficient memory with random latency
// Assumes: Table given by the bench
// Notes: Data bus scrambled when idle
`timescale 1ns/1ps
module ffc_mem_model
  import ffc_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic coef_req, // Fetch
  input wire logic [ADDR_W-1:0] coef_addr, // Index
  output logic coef_ack = 1'h0, // Accept
  output logic coef_rvalid = 1'h0, // Data valid
  output logic [COEF_W-1:0] coef_rdata = 16'h5a5a, // Word
  input wire logic [16*COEF_W-1:0] tbl // Words
);
  logic [ADDR_W-1:0] a;
  always begin
    @(posedge sys_clk);
    if (coef_req) begin
      repeat ($urandom_range(2)) @(posedge sys_clk);
      a = coef_addr;
      coef_ack <= 1'h1;
      @(posedge sys_clk);
      coef_ack <= 1'h0;
      repeat ($urandom_range(2)) @(posedge sys_clk);
      coef_rvalid <= 1'h1;
      coef_rdata <= tbl[a[3:0]*16 +: 16];
      @(posedge sys_clk);
      coef_rvalid <= 1'h0;
      coef_rdata <= ~coef_rdata;
    end
  end
endmodule : ffc_mem_model

// *** verif/ffc_core_tb.sv ***
// Purpose: Self-checking bench for ffc_core
// Assumes: Random stalls on both sides
// Notes: Reference model on integers
`timescale 1ns/1ps
module ffc_core_tb
  import ffc_pkg::*;
;
  logic sys_clk = 1'h0, rst_n = 1'h0, correction_enable_control = 1'h0;
  logic in_valid = 1'h0, in_sof = 1'h0, out_ready = 1'h0;
  logic [DEPTH_W-1:0] depth_sel = 3'h0;
  logic [COMP_W-1:0] in_data = 16'h0, out_data;
  logic in_ready, coef_req, coef_ack, coef_rvalid, out_valid, out_sof;
  logic [ADDR_W-1:0] coef_addr;
  logic [COEF_W-1:0] coef_rdata;
  logic [16*COEF_W-1:0] tbl;
  int error_cnt = 0, samples_checked = 0, k = 0;
  int exp_q[$];
  always #20 sys_clk = ~sys_clk;
  ffc_core u_dut (.sys_clk, .rst_n, .correction_enable_control,
    .depth_sel, .in_valid, .in_ready, .in_data, .in_sof, .coef_req,
    .coef_addr, .coef_ack, .coef_rvalid, .coef_rdata, .out_valid,
    .out_ready, .out_data, .out_sof);
  ffc_mem_model u_mem (.sys_clk, .coef_req, .coef_addr, .coef_ack,
    .coef_rvalid, .coef_rdata, .tbl);
  task automatic check(input string nm, input logic [16:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic complete_run();
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task automatic send(input logic s, e, input int dc);
    int raw, w, mx, v;
    logic rdy;
    mx = (1 << (8 + 2 * dc)) - 1;
    raw = $urandom_range(mx);
    if (s) k = 0;
    w = tbl[k*16 +: 16];
    v = raw - (w >> 10);
    if (v < 0) v = 0;
    v = (v * (w & 32'h3ff)) >> 8;
    if (v > mx) v = mx;
    if (!e) v = raw;
    exp_q.push_back((s << 16) | v);
    k += e;
    in_valid <= 1'h1;
    in_sof <= s;
    correction_enable_control <= e;
    depth_sel <= 3'(dc);
    in_data <= 16'(raw);
    // Ready comes from a flop: read it settled, then pass the edge
    do begin
      @(negedge sys_clk);
      rdy = in_ready;
      @(posedge sys_clk);
    end while (rdy !== 1'h1);
  endtask : send
  always @(posedge sys_clk) out_ready <= ($urandom_range(3) != 0);
  always @(posedge sys_clk)
    if (rst_n && out_valid && out_ready)
      check("out", {out_sof, out_data}, 17'(exp_q.pop_front()));
  initial begin
    void'($urandom(32'h0ecf160c));
    for (int i = 0; i < 16; i++) tbl[i*16 +: 16] = 16'($urandom);
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'h1;
    for (int f = 0; f < 15; f++) begin
      // Depth is read at compute time: drain a frame before changing it
      if (f != 0) begin
        in_valid <= 1'h0;
        while (exp_q.size() != 0) @(posedge sys_clk);
      end
      for (int i = 0; i < 9; i++) send(i == 0, $urandom_range(1), f % 5);
    end
    in_valid <= 1'h0;
    repeat (40) @(posedge sys_clk);
    check("left", 17'(exp_q.size()), 17'h0);
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    complete_run();
  end
endmodule : ffc_core_tb
